//--- logic/hbp_map.svh
// Addresses, field positions, reset values and timing counts of the host bus port
`ifndef HBP_MAP_SVH
`define HBP_MAP_SVH
// Local registers in the device's seven-bit address space
`define HBP_ADDR_PORT_EXT 7'h70
`define HBP_ADDR_KEY_FIRST 7'h71
`define HBP_ADDR_KEY_SECOND 7'h72
`define HBP_ADDR_KEY_THIRD 7'h73
// Watchdog key values, one per key register
`define HBP_KEY_FIRST_VAL 8'h5a
`define HBP_KEY_SECOND_VAL 8'ha5
`define HBP_KEY_THIRD_VAL 8'hc3
// Port extension register: pin levels low nibble, drive enables high nibble
`define HBP_PX_LEVEL_LSB 0
`define HBP_PX_DRIVE_LSB 4
`define HBP_PX_RESET 4'h0
// Timing: clock rate, watchdog window and reset pulse
`define HBP_CLK_MHZ 100
`define HBP_WD_WINDOW_S 2
`define HBP_WD_PULSE_US 125
`define HBP_WD_WINDOW_CYC (`HBP_WD_WINDOW_S * `HBP_CLK_MHZ * 1000000)
`define HBP_WD_PULSE_CYC (`HBP_WD_PULSE_US * `HBP_CLK_MHZ)
// Controller APB byte offsets
`define HBP_APB_CTRL 12'h000
`define HBP_APB_ADDR 12'h004
`define HBP_APB_WDATA 12'h008
`define HBP_APB_CMD 12'h00c
`define HBP_APB_STATUS 12'h010
`define HBP_APB_RDATA 12'h014
// Controller field positions
`define HBP_CTRL_STYLE 0
`define HBP_CTRL_DEMUX 1
`define HBP_CMD_READ 0
`define HBP_ST_BUSY 0
`define HBP_ST_DONE 1
`define HBP_ST_IRQ 2
`define HBP_ST_RESET 3
`endif

//--- logic/hbp_pkg.sv
// Types shared by both ends of the host bus port
package hbp_pkg;
  // Device access sequencer
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_WAIT = 2'b01,
    DEV_DATA = 2'b10,
    DEV_READY = 2'b11
  } hbp_dev_e;
  typedef struct packed {
    hbp_dev_e st;
    logic ale_q;
    logic [6:0] mux_addr;
    logic [6:0] addr;
    logic is_read;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic data_oe;
    logic rdy_oe;
    logic irq_oe;
    logic [3:0] px_level;
    logic [3:0] px_drive;
    logic reg_wr;
    logic reg_rd;
    logic key_wr;
  } hbp_dev_s;
  // Watchdog state
  typedef struct packed {
    logic [1:0] stage;
    logic [31:0] window;
    logic [31:0] pulse;
    logic rst_hi;
    logic rst_lo;
  } hbp_wd_s;
  // Controller sequencer
  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_ALE_HI = 3'b001,
    HST_ALE_LO = 3'b010,
    HST_STROBE = 3'b011,
    HST_END = 3'b100
  } hbp_hst_e;
  typedef struct packed {
    hbp_hst_e st;
    logic style;
    logic demux;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic is_read;
    logic done;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sel_n;
    logic ale;
    logic rds_n;
    logic wrd;
    logic [7:0] bus_out;
    logic bus_oe;
  } hbp_hst_s;
endpackage : hbp_pkg

//--- logic/hbp_link_if.sv
// Pins between the host controller and the device port
`timescale 1ns/1ps
interface hbp_link_if;
  logic bus_style_strap; // Low: separate strobes
  logic addr_mux_strap; // Low: shared address/data
  logic select_a_n;
  logic select_b_n;
  logic [6:0] sep_addr_lines;
  logic ale; // Address latch, also supervision clock
  logic read_or_data_strobe_n;
  logic write_or_dir; // Write strobe or direction
  logic [7:0] host_bus_out;
  logic host_bus_oe;
  logic [7:0] dev_bus_out;
  logic dev_bus_oe;
  logic ready_oe; // Device pulls ready low
  logic irq_oe; // Device pulls interrupt low
  logic host_reset_out;
  logic host_reset_out_n;
  logic [7:0] shared_bus_lines; // Resolved bus, pulled up
  logic ready_n;
  logic irq_n;
  // Wire levels from the enables
  assign shared_bus_lines = dev_bus_oe ? dev_bus_out : (host_bus_oe ? host_bus_out : 8'hff);
  assign ready_n = ~ready_oe;
  assign irq_n = ~irq_oe;
  modport device (
    input bus_style_strap, addr_mux_strap, select_a_n, select_b_n, sep_addr_lines, ale,
    input read_or_data_strobe_n, write_or_dir, shared_bus_lines,
    output dev_bus_out, dev_bus_oe, ready_oe, irq_oe, host_reset_out, host_reset_out_n
  );
  modport host (
    output bus_style_strap, addr_mux_strap, select_a_n, select_b_n, sep_addr_lines, ale,
    output read_or_data_strobe_n, write_or_dir, host_bus_out, host_bus_oe,
    input shared_bus_lines, ready_n, irq_n, host_reset_out, host_reset_out_n
  );
endinterface : hbp_link_if

//--- logic/hbp_watchdog.sv
// Processor watchdog: key sequence, supervision window and reset outputs
`timescale 1ns/1ps
`include "hbp_map.svh"
module hbp_watchdog #(
  parameter logic [31:0] WINDOW_CYC = `HBP_WD_WINDOW_CYC,
  parameter logic [31:0] PULSE_CYC = `HBP_WD_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic key_wr_i, // One-cycle key write
  input wire logic [6:0] key_addr_i,
  input wire logic [7:0] key_data_i,
  input wire logic block_n_i, // Low blocks watchdog resets
  input wire logic por_n_i,
  input wire logic req_n_i,
  output logic reset_hi_o,
  output logic reset_lo_o
);
  import hbp_pkg::*;
  hbp_wd_s s; // Current state
  hbp_wd_s next_s; // Next state

  // True when the write is the key that the stage expects
  function automatic logic key_match(input logic [1:0] stage, input logic [6:0] a, input logic [7:0] d);
    case (stage)
      2'd0: key_match = (a == `HBP_ADDR_KEY_FIRST) && (d == `HBP_KEY_FIRST_VAL);
      2'd1: key_match = (a == `HBP_ADDR_KEY_SECOND) && (d == `HBP_KEY_SECOND_VAL);
      2'd2: key_match = (a == `HBP_ADDR_KEY_THIRD) && (d == `HBP_KEY_THIRD_VAL);
      default: key_match = 1'b0;
    endcase
  endfunction : key_match

  // Sequence, window and pulse
  always_comb
  begin
    next_s = s;
    if (next_s.pulse != 32'h0)
      next_s.pulse = s.pulse - 32'h1;
    if (key_wr_i)
    begin
      if (!key_match(s.stage, key_addr_i, key_data_i))
        next_s.stage = 2'd0;
      else if (s.stage == 2'd2)
      begin
        // Full sequence wins over a window expiring now
        next_s.stage = 2'd0;
        next_s.window = 32'h0;
      end
      else
        next_s.stage = s.stage + 2'd1;
    end
    if (!(key_wr_i && key_match(s.stage, key_addr_i, key_data_i) && s.stage == 2'd2))
    begin
      if (s.window >= WINDOW_CYC - 32'h1)
      begin
        next_s.window = 32'h0;
        next_s.stage = 2'd0;
        if (block_n_i)
          next_s.pulse = PULSE_CYC;
      end
      else
        next_s.window = s.window + 32'h1;
    end
    next_s.rst_hi = (next_s.pulse != 32'h0) || !por_n_i || !req_n_i;
    next_s.rst_lo = !next_s.rst_hi;
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= '{stage: 2'd0, window: 32'h0, pulse: 32'h0, rst_hi: 1'b1, rst_lo: 1'b0};
    else
      s <= next_s;
  end

  assign reset_hi_o = s.rst_hi;
  assign reset_lo_o = s.rst_lo;
endmodule : hbp_watchdog

//--- logic/hbp_dev_end.sv
// Device end of the host bus port: decode, handshake, port extension, watchdog
//
// What this block does
// - Style strap: separate strobes or data strobe
// - Address strap: shared or separate address
// - Both selects low to address device
// - Separate address lines ignored when multiplexed
// - Shared lines carry address then data
// - Address captured at address latch fall
// - Read strobe, or data strobe by style
// - Write strobe, or direction by style
// - Interrupt pulls open-drain output low
// - Read ready only after data valid
// - Write ready when write can conclude
// - Four extension pins read and driven
// - Three keys in order within window
// - Power-on reset asserts processor reset
// - Second reset output is exact inverse
// - Watchdog block input suppresses watchdog reset
// - Reset request asserts both reset outputs
`timescale 1ns/1ps
`include "hbp_map.svh"
module hbp_dev_end #(
  parameter logic [31:0] WD_WINDOW_CYC = `HBP_WD_WINDOW_CYC,
  parameter logic [31:0] WD_PULSE_CYC = `HBP_WD_PULSE_CYC
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  hbp_link_if.device LINK,
  output logic [6:0] REG_ADDR_O, // Register address to core
  output logic [7:0] REG_WDATA_O,
  output logic REG_WR_O, // One-cycle write request
  output logic REG_RD_O, // One-cycle read request
  input wire logic [7:0] REG_RDATA_I,
  input wire logic REG_ACK_I, // Core answer, one cycle
  input wire logic IRQ_REQ_I, // Core interrupt level
  input wire logic [3:0] PORT_EXT_PIN_I,
  output logic [3:0] PORT_EXT_PIN_O,
  output logic [3:0] PORT_EXT_PIN_OE_O,
  input wire logic WATCHDOG_BLOCK_N_I,
  input wire logic HOST_RESET_REQUEST_N_I,
  input wire logic POWER_ON_RESET_N_I
);
  import hbp_pkg::*;
  hbp_dev_s s; // Current state
  hbp_dev_s next_s; // Next state
  logic selected; // Both selects low
  logic rd_req; // Read strobe active
  logic wr_req; // Write strobe active
  logic access; // Selected access in progress
  logic [6:0] cur_addr; // Address of this access

  // Address served inside this block, not by the core
  function automatic logic local_hit(input logic [6:0] a);
    local_hit = (a == `HBP_ADDR_PORT_EXT) || (a == `HBP_ADDR_KEY_FIRST) ||
                (a == `HBP_ADDR_KEY_SECOND) || (a == `HBP_ADDR_KEY_THIRD);
  endfunction : local_hit

  // Key register, takes the watchdog path
  function automatic logic key_hit(input logic [6:0] a);
    key_hit = local_hit(a) && (a != `HBP_ADDR_PORT_EXT);
  endfunction : key_hit

  // Strobe decode by bus style
  always_comb
  begin
    selected = !LINK.select_a_n && !LINK.select_b_n;
    if (!LINK.bus_style_strap)
    begin
      // Separate active-low read and write strobes
      rd_req = !LINK.read_or_data_strobe_n;
      wr_req = !LINK.write_or_dir;
    end
    else
    begin
      // Data strobe qualifies, direction line picks
      rd_req = !LINK.read_or_data_strobe_n && LINK.write_or_dir;
      wr_req = !LINK.read_or_data_strobe_n && !LINK.write_or_dir;
    end
    access = selected && (rd_req || wr_req);
    // Separate lines only count when demultiplexed
    cur_addr = LINK.addr_mux_strap ? LINK.sep_addr_lines : s.mux_addr;
  end

  // Access sequencer and local registers
  always_comb
  begin
    next_s = s;
    next_s.reg_wr = 1'b0;
    next_s.reg_rd = 1'b0;
    next_s.key_wr = 1'b0;
    next_s.irq_oe = IRQ_REQ_I;
    next_s.ale_q = LINK.ale;
    // Latch runs even outside selection, as the host may latch early
    if (!LINK.addr_mux_strap && s.ale_q && !LINK.ale)
      next_s.mux_addr = LINK.shared_bus_lines[6:0];
    case (s.st)
      DEV_IDLE:
      begin
        if (access)
        begin
          next_s.addr = cur_addr;
          next_s.is_read = rd_req;
          next_s.wdata = LINK.shared_bus_lines;
          if (local_hit(cur_addr))
          begin
            // Local registers answer at once
            if (rd_req)
            begin
              next_s.rdata = {s.px_drive, PORT_EXT_PIN_I};
              next_s.st = DEV_DATA;
            end
            else
            begin
              if (key_hit(cur_addr))
                next_s.key_wr = 1'b1;
              else
              begin
                next_s.px_level = LINK.shared_bus_lines[`HBP_PX_LEVEL_LSB +: 4];
                next_s.px_drive = LINK.shared_bus_lines[`HBP_PX_DRIVE_LSB +: 4];
              end
              next_s.st = DEV_READY;
            end
          end
          else
          begin
            // Core register, wait for its answer
            next_s.reg_rd = rd_req;
            next_s.reg_wr = wr_req;
            next_s.st = DEV_WAIT;
          end
        end
      end
      DEV_WAIT:
      begin
        // No timeout: a core that never answers stalls the host
        if (REG_ACK_I)
        begin
          next_s.rdata = REG_RDATA_I;
          next_s.st = s.is_read ? DEV_DATA : DEV_READY;
        end
      end
      DEV_DATA:
      begin
        // Data goes out one cycle before ready
        next_s.data_oe = 1'b1;
        next_s.st = DEV_READY;
      end
      DEV_READY:
      begin
        next_s.rdy_oe = 1'b1;
        if (!access)
        begin
          // Strobe or select released ends the cycle
          next_s.rdy_oe = 1'b0;
          next_s.data_oe = 1'b0;
          next_s.st = DEV_IDLE;
        end
      end
      default:
      begin
        next_s.st = DEV_IDLE;
        next_s.rdy_oe = 1'b0;
        next_s.data_oe = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      s <= '{st: DEV_IDLE, px_level: `HBP_PX_RESET, px_drive: `HBP_PX_RESET, default: '0};
    else
      s <= next_s;
  end

  // Watchdog and processor reset outputs
  hbp_watchdog #(
    .WINDOW_CYC(WD_WINDOW_CYC),
    .PULSE_CYC(WD_PULSE_CYC)
  ) u_hbp_watchdog (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RESET_N_I),
    .key_wr_i(s.key_wr),
    .key_addr_i(s.addr),
    .key_data_i(s.wdata),
    .block_n_i(WATCHDOG_BLOCK_N_I),
    .por_n_i(POWER_ON_RESET_N_I),
    .req_n_i(HOST_RESET_REQUEST_N_I),
    .reset_hi_o(LINK.host_reset_out),
    .reset_lo_o(LINK.host_reset_out_n)
  );

  // All outputs straight from state flops
  assign LINK.dev_bus_out = s.rdata;
  assign LINK.dev_bus_oe = s.data_oe;
  assign LINK.ready_oe = s.rdy_oe;
  assign LINK.irq_oe = s.irq_oe;
  assign REG_ADDR_O = s.addr;
  assign REG_WDATA_O = s.wdata;
  assign REG_WR_O = s.reg_wr;
  assign REG_RD_O = s.reg_rd;
  assign PORT_EXT_PIN_O = s.px_level;
  assign PORT_EXT_PIN_OE_O = s.px_drive;
endmodule : hbp_dev_end

//--- logic/hbp_host_end.sv
// Host end of the host bus port: APB-driven bus cycle generator
`timescale 1ns/1ps
`include "hbp_map.svh"
module hbp_host_end (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  hbp_link_if.host LINK
);
  import hbp_pkg::*;
  hbp_hst_s s; // Current state
  hbp_hst_s next_s; // Next state
  logic busy; // Bus cycle running

  // APB slave and bus cycle sequencer
  always_comb
  begin
    next_s = s;
    busy = (s.st != HST_IDLE);
    // Read data and error prepared in the setup cycle
    if (PSEL_I && !PENABLE_I)
    begin
      next_s.pslverr = 1'b0;
      case (PADDR_I)
        `HBP_APB_CTRL: next_s.prdata = {30'h0, s.demux, s.style};
        `HBP_APB_ADDR: next_s.prdata = {25'h0, s.addr};
        `HBP_APB_WDATA: next_s.prdata = {24'h0, s.wdata};
        `HBP_APB_CMD: next_s.prdata = {31'h0, s.is_read};
        `HBP_APB_STATUS: next_s.prdata = {28'h0, LINK.host_reset_out, !LINK.irq_n, s.done, busy};
        `HBP_APB_RDATA: next_s.prdata = {24'h0, s.rdata};
        default:
        begin
          next_s.prdata = 32'h0;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    // Writes take effect in the access phase
    if (PSEL_I && PENABLE_I && PWRITE_I)
    begin
      case (PADDR_I)
        `HBP_APB_CTRL:
        begin
          next_s.style = PWDATA_I[`HBP_CTRL_STYLE];
          next_s.demux = PWDATA_I[`HBP_CTRL_DEMUX];
        end
        `HBP_APB_ADDR: next_s.addr = PWDATA_I[6:0];
        `HBP_APB_WDATA: next_s.wdata = PWDATA_I[7:0];
        `HBP_APB_CMD:
        begin
          // Ignored while a cycle runs
          if (!busy)
          begin
            next_s.is_read = PWDATA_I[`HBP_CMD_READ];
            next_s.done = 1'b0;
            next_s.st = s.demux ? HST_STROBE : HST_ALE_HI;
          end
        end
        default: next_s.pslverr = s.pslverr;
      endcase
    end
    // Free supervision clock on the latch pin when demultiplexed
    if (s.demux)
      next_s.ale = !s.ale;
    case (s.st)
      HST_IDLE: ;
      HST_ALE_HI:
      begin
        next_s.ale = 1'b1;
        next_s.bus_out = {1'b0, s.addr};
        next_s.bus_oe = 1'b1;
        next_s.st = HST_ALE_LO;
      end
      HST_ALE_LO:
      begin
        next_s.ale = 1'b0;
        next_s.st = HST_STROBE;
      end
      HST_STROBE:
      begin
        next_s.sel_n = 1'b0;
        next_s.bus_out = s.wdata;
        next_s.bus_oe = !s.is_read;
        next_s.rds_n = s.style ? 1'b0 : !s.is_read;
        next_s.wrd = s.is_read;
        if (!s.sel_n && !LINK.ready_n)
        begin
          next_s.rdata = LINK.shared_bus_lines;
          next_s.sel_n = 1'b1;
          next_s.rds_n = 1'b1;
          next_s.wrd = 1'b1;
          next_s.bus_oe = 1'b0;
          next_s.st = HST_END;
        end
      end
      HST_END:
      begin
        // Wait for ready release before a new cycle
        if (LINK.ready_n)
        begin
          next_s.done = 1'b1;
          next_s.st = HST_IDLE;
        end
      end
      default: next_s.st = HST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      s <= '{st: HST_IDLE, pready: 1'b1, sel_n: 1'b1, rds_n: 1'b1, wrd: 1'b1, default: '0};
    else
      s <= next_s;
  end

  assign PRDATA_O = s.prdata;
  assign PREADY_O = s.pready;
  assign PSLVERR_O = s.pslverr;
  assign LINK.bus_style_strap = s.style;
  assign LINK.addr_mux_strap = s.demux;
  assign LINK.select_a_n = s.sel_n;
  assign LINK.select_b_n = s.sel_n;
  assign LINK.sep_addr_lines = s.addr;
  assign LINK.ale = s.ale;
  assign LINK.read_or_data_strobe_n = s.rds_n;
  assign LINK.write_or_dir = s.wrd;
  assign LINK.host_bus_out = s.bus_out;
  assign LINK.host_bus_oe = s.bus_oe;
endmodule : hbp_host_end

//--- sim/hbp_link_sva.sv
// Protocol checker for the link between host end and device end
`timescale 1ns/1ps
module hbp_link_sva (
  input logic SYS_CLK_I,
  input logic RESET_N_I,
  input logic bus_style_strap,
  input logic addr_mux_strap,
  input logic select_a_n,
  input logic select_b_n,
  input logic ale,
  input logic read_or_data_strobe_n,
  input logic write_or_dir,
  input logic host_bus_oe,
  input logic dev_bus_oe,
  input logic ready_oe,
  input logic host_reset_out,
  input logic host_reset_out_n
);
  logic rd; // Read cycle, decoded by bus style
  // Direction pin depends on the style strap
  assign rd = bus_style_strap ? write_or_dir : !read_or_data_strobe_n;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  // Selects released, then the answer is withdrawn
  sequence s_release;
    $rose(select_a_n);
  endsequence
  sequence s_quiet;
    ##[1:2] (!ready_oe && !dev_bus_oe);
  endsequence
  property p_inverse;
    host_reset_out_n == !host_reset_out;
  endproperty
  a_inverse: assert property (p_inverse) else $error("reset outputs not inverse");
  property p_rdy_sel;
    $rose(ready_oe) |-> !select_a_n && !select_b_n;
  endproperty
  a_rdy_sel: assert property (p_rdy_sel) else $error("ready without both selects");
  property p_rd_data;
    $rose(ready_oe) && rd |-> $past(dev_bus_oe) && dev_bus_oe;
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("ready before read data");
  property p_wr_rdy;
    $rose(ready_oe) && !rd |-> !dev_bus_oe;
  endproperty
  a_wr_rdy: assert property (p_wr_rdy) else $error("device drives bus on write");
  property p_drv_read;
    $rose(dev_bus_oe) |-> rd && !select_a_n && !select_b_n;
  endproperty
  a_drv_read: assert property (p_drv_read) else $error("bus driven outside read");
  property p_release;
    s_release |-> s_quiet;
  endproperty
  a_release: assert property (p_release) else $error("answer held after release");
  property p_addr_phase;
    $fell(ale) && !addr_mux_strap && !$past(addr_mux_strap, 2) |-> host_bus_oe;
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("no address at latch fall");
  property p_free_clk;
    addr_mux_strap [*3] |-> ale != $past(ale);
  endproperty
  a_free_clk: assert property (p_free_clk) else $error("latch clock stopped");
  property p_strobe_sel;
    !read_or_data_strobe_n |-> !select_a_n && !select_b_n;
  endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without selects");
endmodule : hbp_link_sva

//--- sim/hbp_tb_top.sv
// Bench joining host end and device end of the host bus port
`timescale 1ns/1ps
`include "hbp_map.svh"
module hbp_tb_top;
  localparam logic [31:0] WIN = 32'd200; // Short window keeps the run brief
  localparam logic [31:0] PUL = 32'd10; // Short reset pulse
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, reg_wr, reg_rd, last_err, prev_rst;
  logic [6:0] reg_addr, cap_a;
  logic [7:0] reg_wdata, cap_d;
  logic [7:0] reg_rdata = 8'h00;
  logic reg_ack = 1'b0;
  logic irq_req = 1'b0;
  logic wd_block_n = 1'b1;
  logic req_n = 1'b1;
  logic por_n = 1'b1;
  logic [3:0] px_in = 4'hf;
  logic [3:0] px_out, px_oe;
  int n_fail = 0;
  int checks_done = 0;
  int n_rise = 0;
  int dly = 0;
  hbp_link_if link ();
  hbp_host_end u_hbp_host_end (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .LINK(link.host));
  hbp_dev_end #(.WD_WINDOW_CYC(WIN), .WD_PULSE_CYC(PUL)) u_hbp_dev_end (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
    .LINK(link.device), .REG_ADDR_O(reg_addr), .REG_WDATA_O(reg_wdata), .REG_WR_O(reg_wr), .REG_RD_O(reg_rd),
    .REG_RDATA_I(reg_rdata), .REG_ACK_I(reg_ack), .IRQ_REQ_I(irq_req), .PORT_EXT_PIN_I(px_in),
    .PORT_EXT_PIN_O(px_out), .PORT_EXT_PIN_OE_O(px_oe), .WATCHDOG_BLOCK_N_I(wd_block_n),
    .HOST_RESET_REQUEST_N_I(req_n), .POWER_ON_RESET_N_I(por_n));
  hbp_link_sva u_hbp_link_sva (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .bus_style_strap(link.bus_style_strap),
    .addr_mux_strap(link.addr_mux_strap), .select_a_n(link.select_a_n), .select_b_n(link.select_b_n),
    .ale(link.ale), .read_or_data_strobe_n(link.read_or_data_strobe_n), .write_or_dir(link.write_or_dir),
    .host_bus_oe(link.host_bus_oe), .dev_bus_oe(link.dev_bus_oe), .ready_oe(link.ready_oe),
    .host_reset_out(link.host_reset_out), .host_reset_out_n(link.host_reset_out_n));
  // Free-running system clock
  always #5 clk = ~clk;
  // Core register model, pulled-up pins and reset pulse counter
  always @(posedge clk)
  begin
    reg_ack <= 1'b0;
    px_in <= (px_oe & px_out) | ~px_oe; // Undriven pins read high
    prev_rst <= link.host_reset_out;
    if (link.host_reset_out === 1'b1 && prev_rst === 1'b0)
      n_rise <= n_rise + 1;
    if (reg_wr === 1'b1)
    begin
      cap_a <= reg_addr;
      cap_d <= reg_wdata;
    end
    if (reg_wr === 1'b1 || reg_rd === 1'b1)
      dly <= 3; // Core answers slowly on purpose
    else if (dly > 0)
    begin
      dly <= dly - 1;
      reg_ack <= (dly == 1);
      reg_rdata <= {1'b0, reg_addr} ^ 8'h3c;
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : chk
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1, "apb hang");
    if (pready !== 1'b1)
      tally_and_finish();
  endtask : apb
  // One link access started and finished through the controller
  task automatic lk(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [31:0] q);
    logic [31:0] s;
    int i;
    apb(1'b1, `HBP_APB_ADDR, {25'h0, a}, s);
    apb(1'b1, `HBP_APB_WDATA, {24'h0, d}, s);
    apb(1'b1, `HBP_APB_CMD, {31'h0, !w}, s);
    i = 0;
    do
    begin
      apb(1'b0, `HBP_APB_STATUS, 32'h0, s);
      i++;
    end
    while ((s[`HBP_ST_BUSY] !== 1'b0 || s[`HBP_ST_DONE] !== 1'b1) && i < 40);
    chk({31'h0, s[`HBP_ST_DONE]}, 32'h1, "link hang");
    // Only a real hang ends the run here, not a late finish
    if (s[`HBP_ST_DONE] !== 1'b1 || s[`HBP_ST_BUSY] !== 1'b0)
      tally_and_finish();
    apb(1'b0, `HBP_APB_RDATA, 32'h0, q);
  endtask : lk
  // Bounded wait for a level on the processor reset output
  task automatic wait_rst(input logic lvl);
    int i;
    i = 0;
    while (link.host_reset_out !== lvl && i < 400)
    begin
      @(posedge clk);
      i++;
    end
    chk({31'h0, link.host_reset_out}, {31'h0, lvl}, "reset wait");
    if (link.host_reset_out !== lvl)
      tally_and_finish();
  endtask : wait_rst
  task automatic t_access();
    logic [31:0] q;
    logic [6:0] a;
    repeat (3) @(posedge clk);
    chk({30'h0, link.host_reset_out, link.host_reset_out_n}, 32'h1, "idle reset outputs");
    for (int m = 0; m < 4; m++)
    begin
      a = 7'h11 + 7'(m * 9);
      apb(1'b1, `HBP_APB_CTRL, 32'(m), q);
      lk(1'b1, a, 8'h81 ^ 8'(m), q);
      chk({25'h0, cap_a}, {25'h0, a}, "write addr");
      chk({24'h0, cap_d}, {24'h0, 8'h81 ^ 8'(m)}, "write data");
      lk(1'b0, a, 8'h00, q);
      chk(q, {24'h0, {1'b0, a} ^ 8'h3c}, "read data");
    end
    lk(1'b1, `HBP_ADDR_PORT_EXT, 8'h93, q);
    chk({24'h0, px_oe, px_out}, 32'h93, "pin drive");
    lk(1'b0, `HBP_ADDR_PORT_EXT, 8'h00, q);
    chk(q, 32'h97, "pin readback");
    apb(1'b0, 12'h020, 32'h0, q);
    chk({31'h0, last_err}, 32'h1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
  endtask : t_access
  task automatic t_irq();
    logic [31:0] q;
    irq_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, link.irq_n}, 32'h0, "irq low");
    apb(1'b0, `HBP_APB_STATUS, 32'h0, q);
    chk({31'h0, q[`HBP_ST_IRQ]}, 32'h1, "irq status");
    irq_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, link.irq_n}, 32'h1, "irq released");
  endtask : t_irq
  // Key sequence written through the link; a wrong second key is followed by the right one
  task automatic keys(input logic [7:0] k2);
    logic [31:0] q;
    lk(1'b1, `HBP_ADDR_KEY_FIRST, `HBP_KEY_FIRST_VAL, q);
    lk(1'b1, `HBP_ADDR_KEY_SECOND, k2, q);
    // Completes only if the wrong key did not abandon the sequence
    if (k2 != `HBP_KEY_SECOND_VAL)
      lk(1'b1, `HBP_ADDR_KEY_SECOND, `HBP_KEY_SECOND_VAL, q);
    lk(1'b1, `HBP_ADDR_KEY_THIRD, `HBP_KEY_THIRD_VAL, q);
  endtask : keys
  task automatic t_wd();
    int r;
    int w;
    // Wait out one expiry so the window starts fresh
    wait_rst(1'b1);
    wait_rst(1'b0);
    keys(`HBP_KEY_SECOND_VAL);
    r = n_rise;
    repeat (60) @(posedge clk);
    keys(`HBP_KEY_SECOND_VAL);
    repeat (60) @(posedge clk);
    keys(`HBP_KEY_SECOND_VAL);
    // Span exceeds one window, so only restarts keep the pulse away
    chk(32'(n_rise - r), 32'h0, "pulse despite keys");
    r = n_rise;
    keys(8'h00);
    // Expiry of the last good window lands inside this wait
    repeat (160) @(posedge clk);
    chk(32'(n_rise - r), 32'h1, "pulse after broken keys");
    wait_rst(1'b1);
    w = 0;
    while (link.host_reset_out === 1'b1 && w < 50)
    begin
      w++;
      @(posedge clk);
    end
    chk(32'(w), PUL, "pulse width");
    wd_block_n <= 1'b0;
    r = n_rise;
    repeat (450) @(posedge clk);
    chk(32'(n_rise - r), 32'h0, "blocked pulse");
    req_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({30'h0, link.host_reset_out, link.host_reset_out_n}, 32'h2, "request reset");
    req_n <= 1'b1;
    por_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({30'h0, link.host_reset_out, link.host_reset_out_n}, 32'h2, "power-on reset");
    por_n <= 1'b1;
    wd_block_n <= 1'b1;
  endtask : t_wd
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_access();
    t_irq();
    t_wd();
    tally_and_finish();
  end
endmodule : hbp_tb_top
